// ### rtl/fca_pkg.sv
package fca_pkg;
    localparam logic [17:0] FCA_FCR_ADDR = 18'h0FFA0;
    localparam int FCA_IDX_W = 13;
    localparam int FCA_WORDS = 8192;
    localparam int FCA_CNT_W = 19;
    localparam int FCA_P_PERMIT = 0;
    localparam int FCA_P_ERASE = 1;
    localparam int FCA_P_BUSY = 2;
    localparam int FCA_P_GUARD = 2;
    localparam int FCA_P_FAIL = 3;
    localparam int FCA_P_VALID = 4;
    localparam int FCA_P_PULSE = 5;
    localparam int FCA_P_DW = 7;
    localparam int FCA_P_BLK = 8;
    localparam int FCA_P_HOLD = 15;
    localparam logic FCA_GUARD_RST = 1'b1;
    localparam logic [18:0] FCA_PULSE0 = 19'h00080;
    localparam logic [18:0] FCA_PULSE1 = 19'h00800;
    localparam logic [18:0] FCA_PULSE2 = 19'h08000;
    localparam logic [18:0] FCA_PULSE3 = 19'h40000;

    typedef enum logic [1:0] {
        FCA_IDLE = 2'b00,
        FCA_PULSE = 2'b01,
        FCA_SWEEP = 2'b10
    } fca_seq_t;

    typedef struct packed {
        logic valid;
        logic wr;
        logic direct;
        logic from_flash;
        logic [17:0] addr;
        logic [15:0] wdata;
    } fca_req_t;

    typedef struct packed {
        logic hold;
        logic [1:0] blk;
        logic dw;
        logic [1:0] pulse;
        logic fail;
        logic fee;
        logic write_permit;
    } fca_fcr_t;

    typedef struct packed {
        fca_seq_t seq;
        fca_fcr_t flash_operation_control;
        logic busy;
        logic guard;
        logic seg1;
        logic strap_done;
        logic vpp_meta;
        logic vpp_ok;
        logic lo_valid;
        logic [15:0] lo_data;
        logic op_erase;
        logic [1:0] op_blk;
        logic [12:0] op_idx;
        logic [31:0] op_data;
        logic [31:0] op_mask;
        logic [12:0] sweep_idx;
        logic [31:0] rdata;
        logic rvalid;
        logic rdenied;
    } fca_state_t;

    localparam fca_state_t FCA_STATE_RST = '{seq: FCA_IDLE, guard: FCA_GUARD_RST, default: '0};

    typedef struct packed {
        logic active;
        logic done;
        logic [18:0] cnt;
        logic [18:0] limit;
    } fca_tmr_t;

    function automatic logic [12:0] fca_block_first(input logic [1:0] blk);
        case (blk)
            2'h0: fca_block_first = 13'h0000;
            2'h1: fca_block_first = 13'h0C00;
            2'h2: fca_block_first = 13'h1800;
            default: fca_block_first = 13'h1E00;
        endcase
    endfunction

    function automatic logic [12:0] fca_block_last(input logic [1:0] blk);
        case (blk)
            2'h0: fca_block_last = 13'h0BFF;
            2'h1: fca_block_last = 13'h17FF;
            2'h2: fca_block_last = 13'h1DFF;
            default: fca_block_last = 13'h1FFF;
        endcase
    endfunction
endpackage

// ### rtl/fca_pulse_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fca_pulse_timer
    import fca_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic nrst, // Async reset, active low
    input wire logic start, // Begin one pulse
    input wire logic [FCA_CNT_W-1:0] limit, // Pulse length in cycles
    output logic done // End of pulse
);
    fca_tmr_t s;
    fca_tmr_t n;

    always_comb begin
        n = s;
        n.done = 1'b0;
        if (s.active) begin
            if (s.cnt == s.limit - 19'h00001) begin
                n.active = 1'b0;
                n.done = 1'b1;
            end else begin
                n.cnt = s.cnt + 19'h00001;
            end
        end else if (start) begin
            n.active = 1'b1;
            n.cnt = 19'h00000;
            n.limit = limit;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign done = s.done;

    pulse_load_a: assert property (@(posedge clk) disable iff (!nrst)
        start && !s.active |=> s.active && s.cnt == 19'h00000 && s.limit == $past(limit))
        else $error("pulse timer did not load");
    pulse_len_a: assert property (@(posedge clk) disable iff (!nrst)
        s.done |-> $past(s.active) && $past(s.cnt) == s.limit - 19'h00001)
        else $error("pulse ended at wrong count");
endmodule
`default_nettype wire

// ### rtl/fca_flash_array.sv
`timescale 1ns/1ps
`default_nettype none
module fca_flash_array
    import fca_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic nrst, // Reset, checks only
    input wire logic [FCA_IDX_W-1:0] rd_idx, // Read word index
    output logic [31:0] rd_data, // Read word
    input wire logic wr_en, // Cell update strobe
    input wire logic wr_erase, // Set bits instead of clearing
    input wire logic [FCA_IDX_W-1:0] wr_idx, // Update word index
    input wire logic [31:0] wr_data, // Program data
    input wire logic [31:0] wr_mask // Bits touched
);
    logic [31:0] mem [FCA_WORDS];

    assign rd_data = mem[rd_idx];

    // Programming only clears bits; erase only sets them
    always_ff @(posedge clk) begin
        if (wr_en) begin
            if (wr_erase) begin
                mem[wr_idx] <= mem[wr_idx] | wr_mask;
            end else begin
                mem[wr_idx] <= mem[wr_idx] & (wr_data | ~wr_mask);
            end
        end
    end

    erase_ones_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_en && wr_erase && wr_mask == 32'hFFFFFFFF |=> mem[$past(wr_idx)] == 32'hFFFFFFFF)
        else $error("erased word not all ones");
endmodule
`default_nettype wire

// ### rtl/fca_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module fca_ctrl
    import fca_pkg::*;
#(
    parameter logic [FCA_CNT_W-1:0] PULSE_CYC2 = FCA_PULSE2, // Pulse width, setting 2
    parameter logic [FCA_CNT_W-1:0] PULSE_CYC3 = FCA_PULSE3 // Pulse width, setting 3
) (
    input wire logic CLK, // 10 MHz clock
    input wire logic NRST, // Async reset, active low
    input wire logic MAP_SEG1, // Strap: array in segment 1
    input wire logic PROT_OPTION, // General protection option enabled
    input wire logic VPP_PIN, // Programming voltage valid pin
    input wire logic UNLOCK, // Key sequence completed
    input wire fca_req_t REQ, // CPU access
    output logic [31:0] RDATA, // Read data
    output logic RVALID, // Read answered
    output logic RDENIED, // Read refused by guard
    output logic WRITE_MODE, // Writing mode active
    output logic BUSY // Operation in progress
);
    fca_state_t s;
    fca_state_t n;
    logic in_array;
    logic at_sfr;
    logic fcr_hit;
    logic rd_req;
    logic wr_req;
    logic guard_on;
    logic arr_wr_ok;
    logic tmr_start;
    logic tmr_done;
    logic [FCA_CNT_W-1:0] tmr_limit;
    logic arr_wr;
    logic arr_erase;
    logic [FCA_IDX_W-1:0] arr_wr_idx;
    logic [31:0] arr_wr_data;
    logic [31:0] arr_wr_mask;
    logic [31:0] arr_rd;

    function automatic logic [15:0] fcr_word(input fca_state_t st);
        logic [15:0] w;
        w = 16'h0000;
        w[FCA_P_PERMIT] = st.flash_operation_control.write_permit;
        w[FCA_P_ERASE] = st.flash_operation_control.fee;
        w[FCA_P_BUSY] = st.busy;
        w[FCA_P_FAIL] = st.flash_operation_control.fail;
        w[FCA_P_VALID] = st.vpp_ok;
        w[FCA_P_PULSE +: 2] = st.flash_operation_control.pulse;
        w[FCA_P_DW] = st.flash_operation_control.dw;
        w[FCA_P_BLK +: 2] = st.flash_operation_control.blk;
        w[FCA_P_HOLD] = st.flash_operation_control.hold;
        return w;
    endfunction

    function automatic logic [FCA_CNT_W-1:0] pulse_cycles(input logic [1:0] sel);
        case (sel)
            2'h0: pulse_cycles = FCA_PULSE0;
            2'h1: pulse_cycles = FCA_PULSE1;
            2'h2: pulse_cycles = PULSE_CYC2;
            default: pulse_cycles = PULSE_CYC3;
        endcase
    endfunction

    // Address decode
    assign in_array = (REQ.addr[17:16] == {1'b0, s.seg1}) && !REQ.addr[15];
    assign at_sfr = REQ.addr == FCA_FCR_ADDR;
    // Register reachable only in writing mode, by direct even word access
    assign fcr_hit = s.flash_operation_control.hold && REQ.direct
        && ((in_array && !REQ.addr[0]) || at_sfr);
    assign rd_req = REQ.valid && !REQ.wr;
    assign wr_req = REQ.valid && REQ.wr;
    assign guard_on = s.guard && PROT_OPTION;
    assign arr_wr_ok = wr_req && s.flash_operation_control.hold && !REQ.direct && in_array
        && !REQ.addr[0] && s.flash_operation_control.write_permit && s.seq == FCA_IDLE;

    // Cell update path
    assign tmr_limit = pulse_cycles(s.flash_operation_control.pulse);
    assign arr_erase = s.seq == FCA_SWEEP;
    assign arr_wr = arr_erase || (s.seq == FCA_PULSE && tmr_done && !s.op_erase);
    assign arr_wr_idx = arr_erase ? s.sweep_idx : s.op_idx;
    assign arr_wr_data = arr_erase ? 32'hFFFFFFFF : s.op_data;
    assign arr_wr_mask = arr_erase ? 32'hFFFFFFFF : s.op_mask;

    always_comb begin
        n = s;
        tmr_start = 1'b0;
        n.vpp_meta = VPP_PIN;
        n.vpp_ok = s.vpp_meta;
        n.rvalid = 1'b0;
        n.rdenied = 1'b0;
        if (!s.strap_done) begin
            n.seg1 = MAP_SEG1;
            n.strap_done = 1'b1;
        end
        // Read answers
        if (rd_req && fcr_hit) begin
            n.rvalid = 1'b1;
            n.rdata = {16'h0000, fcr_word(s)};
        end else if (rd_req && in_array) begin
            n.rvalid = 1'b1;
            if (guard_on && !REQ.from_flash) begin
                n.rdenied = 1'b1;
                n.rdata = 32'h00000000;
            end else begin
                n.rdata = arr_rd;
            end
        end
        // Register writes; locked outside writing mode, except a guard bit write from flash at the register address
        if (wr_req && fcr_hit) begin
            n.flash_operation_control.write_permit = REQ.wdata[FCA_P_PERMIT];
            n.flash_operation_control.fee = REQ.wdata[FCA_P_ERASE];
            n.flash_operation_control.fail = s.flash_operation_control.fail && REQ.wdata[FCA_P_FAIL];
            n.flash_operation_control.pulse = REQ.wdata[FCA_P_PULSE +: 2];
            n.flash_operation_control.dw = REQ.wdata[FCA_P_DW];
            n.flash_operation_control.blk = REQ.wdata[FCA_P_BLK +: 2];
            n.guard = REQ.wdata[FCA_P_GUARD];
            n.flash_operation_control.hold = REQ.wdata[FCA_P_HOLD];
        end else if (wr_req && at_sfr && REQ.from_flash) begin
            n.guard = REQ.wdata[FCA_P_GUARD];
        end
        if (UNLOCK && !s.flash_operation_control.hold) begin
            n.flash_operation_control.hold = 1'b1;
        end
        case (s.seq)
            FCA_IDLE: begin
                if (arr_wr_ok) begin
                    if (s.flash_operation_control.fee) begin
                        n.op_erase = 1'b1;
                        n.op_blk = s.flash_operation_control.blk;
                        tmr_start = 1'b1;
                    end else if (!s.flash_operation_control.dw) begin
                        n.op_erase = 1'b0;
                        n.op_idx = REQ.addr[14:2];
                        n.op_data = {REQ.wdata, REQ.wdata};
                        n.op_mask = REQ.addr[1] ? 32'hFFFF0000 : 32'h0000FFFF;
                        tmr_start = 1'b1;
                    end else if (!REQ.addr[1]) begin
                        n.lo_valid = 1'b1;
                        n.lo_data = REQ.wdata;
                    end else if (s.lo_valid) begin
                        n.lo_valid = 1'b0;
                        n.op_erase = 1'b0;
                        n.op_idx = REQ.addr[14:2];
                        n.op_data = {REQ.wdata, s.lo_data};
                        n.op_mask = 32'hFFFFFFFF;
                        tmr_start = 1'b1;
                    end
                end
                if (tmr_start) begin
                    n.busy = 1'b1;
                    n.seq = FCA_PULSE;
                end
            end
            FCA_PULSE: begin
                if (tmr_done) begin
                    if (s.op_erase) begin
                        n.seq = FCA_SWEEP;
                        n.sweep_idx = fca_block_first(s.op_blk);
                    end else begin
                        n.seq = FCA_IDLE;
                        n.busy = 1'b0;
                    end
                end
            end
            FCA_SWEEP: begin
                if (s.sweep_idx == fca_block_last(s.op_blk)) begin
                    n.seq = FCA_IDLE;
                    n.busy = 1'b0;
                end else begin
                    n.sweep_idx = s.sweep_idx + 13'h0001;
                end
            end
            default: begin
                n.seq = FCA_IDLE;
                n.busy = 1'b0;
            end
        endcase
        // Failure capture wins over a clearing write
        if (s.busy && !s.vpp_ok) begin
            n.flash_operation_control.fail = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s <= FCA_STATE_RST;
        end else begin
            s <= n;
        end
    end

    fca_pulse_timer u_tmr (
        .clk(CLK),
        .nrst(NRST),
        .start(tmr_start),
        .limit(tmr_limit),
        .done(tmr_done)
    );

    fca_flash_array u_arr (
        .clk(CLK),
        .nrst(NRST),
        .rd_idx(REQ.addr[14:2]),
        .rd_data(arr_rd),
        .wr_en(arr_wr),
        .wr_erase(arr_erase),
        .wr_idx(arr_wr_idx),
        .wr_data(arr_wr_data),
        .wr_mask(arr_wr_mask)
    );

    assign RDATA = s.rdata;
    assign RVALID = s.rvalid;
    assign RDENIED = s.rdenied;
    assign WRITE_MODE = s.flash_operation_control.hold;
    assign BUSY = s.busy;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    sequence fcr_rd_s;
        rd_req && fcr_hit;
    endsequence

    sequence fcr_wr_s;
        wr_req && fcr_hit;
    endsequence

    sequence op_start_s;
        s.seq == FCA_IDLE && tmr_start;
    endsequence

    sequence pulse_run_s;
        s.busy && s.seq == FCA_PULSE;
    endsequence

    std_lock_a: assert property (
        wr_req && !s.flash_operation_control.hold && !UNLOCK && !s.busy |=> $stable(s.flash_operation_control))
        else $error("control register changed in standard mode");
    unlock_only_a: assert property (
        !s.flash_operation_control.hold ##1 s.flash_operation_control.hold |-> $past(UNLOCK))
        else $error("writing mode entered without key sequence");
    hold_exit_a: assert property (
        fcr_wr_s and !REQ.wdata[FCA_P_HOLD] |=> !s.flash_operation_control.hold && !WRITE_MODE)
        else $error("writing mode not left");
    busy_read_a: assert property (
        fcr_rd_s |=> RVALID && RDATA[FCA_P_BUSY] == $past(s.busy))
        else $error("busy bit misreported");
    vpp_read_a: assert property (
        fcr_rd_s |=> RDATA[FCA_P_VALID] == $past(s.vpp_ok) && RDATA[31:16] == 16'h0000)
        else $error("voltage valid bit misreported");
    guard_deny_a: assert property (
        rd_req && in_array && !fcr_hit && guard_on && !REQ.from_flash
        |=> RVALID && RDENIED && RDATA == 32'h00000000)
        else $error("guarded read not refused");
    fetch_word_a: assert property (
        rd_req && in_array && !fcr_hit && !(guard_on && !REQ.from_flash)
        |=> RVALID && !RDENIED && RDATA === $past(arr_rd))
        else $error("array word not returned");
    guard_write_a: assert property (
        fcr_wr_s |=> s.guard == $past(REQ.wdata[FCA_P_GUARD]))
        else $error("guard bit not written");
    fail_set_a: assert property (
        s.busy && !s.vpp_ok |=> s.flash_operation_control.fail)
        else $error("voltage failure not flagged");
    op_start_a: assert property (
        op_start_s |=> pulse_run_s ##1 (s.busy || s.seq == FCA_IDLE))
        else $error("operation start sequence broken");
    no_permit_a: assert property (
        wr_req && !REQ.direct && !s.flash_operation_control.write_permit && !s.busy |=> !s.busy)
        else $error("operation started without permit");
    width_sel_a: assert property (
        op_start_s and (!s.flash_operation_control.fee && !s.flash_operation_control.dw)
        |=> s.op_mask == 32'h0000FFFF || s.op_mask == 32'hFFFF0000)
        else $error("16-bit program mask wrong");
    blk_sel_a: assert property (
        op_start_s and s.flash_operation_control.fee |=> s.op_erase && s.op_blk == $past(s.flash_operation_control.blk))
        else $error("erase block not latched");
    erase_scope_a: assert property (
        arr_wr && arr_erase |-> s.sweep_idx >= fca_block_first(s.op_blk)
        && s.sweep_idx <= fca_block_last(s.op_blk))
        else $error("erase left its block");
    prog_done_a: assert property (
        pulse_run_s and tmr_done and !s.op_erase |=> !s.busy && s.seq == FCA_IDLE)
        else $error("busy not cleared after program");
    sweep_done_a: assert property (
        s.seq == FCA_SWEEP && s.sweep_idx == fca_block_last(s.op_blk)
        |=> !s.busy && s.seq == FCA_IDLE)
        else $error("busy not cleared after erase");
    map_fixed_a: assert property (
        s.strap_done |=> $stable(s.seg1))
        else $error("array mapping changed after init");
endmodule
`default_nettype wire

// ### verification/fca_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module fca_cpu_model
    import fca_pkg::*;
(
    input wire logic clk, // Clock
    output fca_req_t req, // Access request
    output logic unlock, // Key sequence done
    input wire logic [31:0] rdata, // Read data
    input wire logic rvalid, // Read answered
    input wire logic rdenied // Read refused
);
    initial begin
        req = '0;
        unlock = 1'b0;
    end

    // Key sequence pulse, needed before any register write except a guard bit write from flash at the register address
    task automatic key();
        @(negedge clk);
        unlock = 1'b1;
        @(negedge clk);
        unlock = 1'b0;
    endtask

    // Word write; callers keep the hold bit set to stay in writing mode
    task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic dir,
                      input logic ff);
        @(negedge clk);
        req = '{valid: 1'b1, wr: 1'b1, direct: dir, from_flash: ff, addr: a, wdata: d};
        @(negedge clk);
        req.valid = 1'b0;
        req.addr = ~a;
        req.wdata = ~d;
    endtask

    // Read; answer stands from the taking edge and is sampled half a cycle later
    task automatic rd(input logic [17:0] a, input logic dir, input logic ff,
                      output logic [31:0] d, output logic ok, output logic den);
        @(negedge clk);
        req = '{valid: 1'b1, wr: 1'b0, direct: dir, from_flash: ff, addr: a, wdata: 16'h0000};
        @(negedge clk);
        ok = rvalid;
        den = rdenied;
        d = rdata;
        req.valid = 1'b0;
        req.addr = ~a;
    endtask
endmodule
`default_nettype wire

// ### verification/flash_control_and_access_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module flash_control_and_access_tb_top
    import fca_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic map_seg1 = 1'b0;
    logic prot_option = 1'b1;
    logic vpp_pin = 1'b1;
    logic unlock;
    fca_req_t req;
    logic [31:0] rdata;
    logic rvalid;
    logic rdenied;
    logic write_mode;
    logic busy;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] d;
    logic ok;
    logic den;
    int n;

    initial begin
        forever #50 clk = ~clk;
    end

    fca_ctrl #(.PULSE_CYC2(19'h00010), .PULSE_CYC3(19'h00020)) i_fca_ctrl (
        .CLK(clk), .NRST(nrst), .MAP_SEG1(map_seg1), .PROT_OPTION(prot_option),
        .VPP_PIN(vpp_pin), .UNLOCK(unlock), .REQ(req), .RDATA(rdata), .RVALID(rvalid),
        .RDENIED(rdenied), .WRITE_MODE(write_mode), .BUSY(busy));

    fca_cpu_model i_fca_cpu_model (
        .clk(clk), .req(req), .unlock(unlock), .rdata(rdata), .rvalid(rvalid),
        .rdenied(rdenied));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Counts cycles until the operation ends, checking duration bounds
    task automatic wait_op(input int lo, input int hi);
        n = 0;
        chk("busy_start", 32'h1, {31'h0, busy});
        while (busy !== 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n < lo || n > hi) begin
            miscompares++;
            $display("BAD op_cycles expected %0d..%0d seen %0d", lo, hi, n);
        end
        compares++;
    endtask

    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        // Standard mode, guard and lock
        i_fca_cpu_model.rd(18'h06000, 1'b1, 1'b0, d, ok, den);
        chk("guard_deny", 32'h1, {31'h0, den});
        chk("guard_data", 32'h0, d);
        i_fca_cpu_model.wr(18'h0FFA0, 16'h8001, 1'b1, 1'b0);
        chk("locked", 32'h0, {31'h0, write_mode});
        i_fca_cpu_model.wr(18'h0FFA0, 16'h0000, 1'b1, 1'b1);
        i_fca_cpu_model.rd(18'h06000, 1'b0, 1'b0, d, ok, den);
        chk("guard_off", 32'h2, {30'h0, ok, den});
        $display("test standard done");
        // Writing mode and register view
        i_fca_cpu_model.key();
        chk("wmode_on", 32'h1, {31'h0, write_mode});
        i_fca_cpu_model.rd(18'h00100, 1'b1, 1'b0, d, ok, den);
        chk("fcr_read", 32'h00008010, d);
        // Erase block 2 with shortened pulse setting 2
        i_fca_cpu_model.wr(18'h0FFA0, 16'h8243, 1'b1, 1'b0);
        chk("no_start", 32'h0, {31'h0, busy});
        i_fca_cpu_model.wr(18'h06000, 16'h0000, 1'b0, 1'b0);
        wait_op(16 + 1536 - 3, 16 + 1536 + 4);
        i_fca_cpu_model.rd(18'h077FC, 1'b0, 1'b0, d, ok, den);
        chk("erased_last", 32'hFFFFFFFF, d);
        $display("test erase2 done");
        // 16-bit programming with pulse setting 0, 32-bit programming with pulse setting 1
        i_fca_cpu_model.wr(18'h0FFA0, 16'h8301, 1'b1, 1'b0);
        i_fca_cpu_model.wr(18'h06000, 16'h1234, 1'b0, 1'b0);
        wait_op(128 - 3, 128 + 4);
        i_fca_cpu_model.rd(18'h06000, 1'b0, 1'b0, d, ok, den);
        chk("prog16", 32'hFFFF1234, d);
        i_fca_cpu_model.wr(18'h0FFA0, 16'h80A1, 1'b1, 1'b0);
        i_fca_cpu_model.wr(18'h06004, 16'hABCD, 1'b0, 1'b0);
        chk("dw_low_wait", 32'h0, {31'h0, busy});
        i_fca_cpu_model.wr(18'h06006, 16'h5678, 1'b0, 1'b0);
        wait_op(2048 - 3, 2048 + 4);
        i_fca_cpu_model.rd(18'h06004, 1'b0, 1'b0, d, ok, den);
        chk("prog32", 32'h5678ABCD, d);
        $display("test program done");
        // Voltage failure during an operation
        vpp_pin = 1'b0;
        repeat (3) @(negedge clk);
        i_fca_cpu_model.wr(18'h06008, 16'h0F0F, 1'b0, 1'b0);
        i_fca_cpu_model.wr(18'h06008, 16'h0F0F, 1'b0, 1'b0);
        i_fca_cpu_model.wr(18'h0600A, 16'h0F0F, 1'b0, 1'b0);
        wait_op(2048 - 3, 2048 + 4);
        i_fca_cpu_model.rd(18'h0FFA0, 1'b1, 1'b0, d, ok, den);
        chk("vpp_bits", 32'h1, {30'h0, d[4:3]});
        vpp_pin = 1'b1;
        i_fca_cpu_model.wr(18'h0FFA0, 16'h8363, 1'b1, 1'b0);
        repeat (2) @(negedge clk);
        i_fca_cpu_model.rd(18'h0FFA0, 1'b1, 1'b0, d, ok, den);
        chk("fail_clear", 32'h00008373, d);
        $display("test vpp done");
        // Erase block 3 leaves block 2 intact
        i_fca_cpu_model.wr(18'h07800, 16'h0000, 1'b0, 1'b0);
        wait_op(32 + 512 - 3, 32 + 512 + 4);
        i_fca_cpu_model.rd(18'h07FFC, 1'b0, 1'b0, d, ok, den);
        chk("blk3_erased", 32'hFFFFFFFF, d);
        i_fca_cpu_model.rd(18'h06000, 1'b0, 1'b0, d, ok, den);
        chk("blk2_kept", 32'hFFFF1234, d);
        i_fca_cpu_model.wr(18'h00100, 16'h0000, 1'b1, 1'b0);
        chk("wmode_off", 32'h0, {31'h0, write_mode});
        i_fca_cpu_model.rd(18'h06004, 1'b1, 1'b0, d, ok, den);
        chk("direct_rom", 32'h5678ABCD, d);
        $display("test erase3 done");
        // Remap to segment 1
        @(negedge clk);
        nrst = 1'b0;
        map_seg1 = 1'b1;
        prot_option = 1'b0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        i_fca_cpu_model.rd(18'h16000, 1'b1, 1'b0, d, ok, den);
        chk("seg1_read", 32'hFFFF1234, d);
        i_fca_cpu_model.rd(18'h06000, 1'b1, 1'b0, d, ok, den);
        chk("seg0_empty", 32'h0, {31'h0, ok});
        $display("test remap done");
        stop_test();
    end
endmodule
`default_nettype wire
